/* File: irsc_baud.sv */
`timescale 1ns/100ps
module irsc_baud (
    input  wire logic                          core_clk,
    input  wire logic                          resetn,
    input  wire logic                          load,
    input  wire logic [irsc_pkg::RELOAD_W-1:0] reload,
    output logic      [irsc_pkg::RELOAD_W-1:0] cnt,
    output logic                               expired
);
    import irsc_pkg::*;

    logic [RELOAD_W-1:0] cnt_reg;
    logic [RELOAD_W-1:0] cnt_next;
    logic                run_reg;
    logic                run_next;

    assign expired = run_reg && (cnt_reg == '0);
    assign cnt     = cnt_reg;

    // One decrement per system clock
    always_comb begin
        cnt_next = cnt_reg;
        run_next = run_reg;
        if (load) begin
            cnt_next = reload;
            run_next = 1'b1;
        end else if (expired) begin
            run_next = 1'b0;
        end else if (run_reg) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            run_reg <= run_next;
        end
    end

    chk_cnt_dec : assert property (@(posedge core_clk) disable iff (!resetn)
        (run_reg && !load && cnt_reg != '0) |=> (cnt_reg == $past(cnt_reg) - 1'b1))
        else $error("countdown did not step by one");

endmodule : irsc_baud

/* File: irsc_peer.sv */
`timescale 1ns/100ps
module irsc_peer (
    input  wire logic             core_clk,
    input  wire logic             pull_scl,
    input  wire logic             pull_sda,
    output irsc_pkg::irsc_lines_t peer_oe
);
    import irsc_pkg::*;
    irsc_lines_t pull_reg = '0;
    // Another master on the open-drain bus: it only ever pulls a line low, never drives it high
    always @(posedge core_clk) begin
        pull_reg.scl <= pull_scl;
        pull_reg.sda <= pull_sda;
    end
    assign peer_oe = pull_reg;
endmodule : irsc_peer

/* File: irsc_pkg.sv */
package irsc_pkg;

    // Bus widths and register byte offsets on the APB
    localparam int          ADDR_W     = 8;
    localparam int          DATA_W     = 32;
    localparam int          REG_W      = 8;
    localparam int          RELOAD_W   = 7;
    localparam logic [7:0]  OFF_BUF    = 8'h00;
    localparam logic [7:0]  OFF_RELOAD = 8'h04;
    localparam logic [7:0]  OFF_CTL1   = 8'h08;
    localparam logic [7:0]  OFF_CTL2   = 8'h0C;
    localparam logic [7:0]  OFF_STAT   = 8'h10;
    localparam logic [7:0]  OFF_EVT    = 8'h14;

    // Field positions
    localparam int CTL1_WCOL  = 7;
    localparam int CTL1_EN    = 5;
    localparam int CTL2_ACKDT = 5;
    localparam int CTL2_ACK_SEQ_ENABLE = 4;
    localparam int CTL2_PEN   = 2;
    localparam int CTL2_RESTART_SEQ_ENABLE  = 1;
    localparam int CTL2_SEN   = 0;
    localparam int STAT_P     = 4;
    localparam int STAT_S     = 3;
    localparam int EVT_COLL   = 0;
    localparam int EVT_PORT   = 1;

    // Reset value and sequence-enable mask
    localparam logic [7:0]  REG_RST    = 8'h00;
    localparam logic [7:0]  SEQ_MASK   = 8'h17;

    typedef struct packed {
        logic scl;
        logic sda;
    } irsc_lines_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_SEN_CNT1, ST_SEN_CNT2,
        ST_RS_SDA, ST_RS_CNT1, ST_RS_SCL, ST_RS_CNT2, ST_RS_CNT3,
        ST_SP_SDA, ST_SP_SCL, ST_SP_CNT1, ST_SP_CNT2,
        ST_AK_CNT1, ST_AK_SCL, ST_AK_CNT2
    } irsc_state_t;

endpackage : irsc_pkg

/* File: irsc_sync.sv */
`timescale 1ns/100ps
module irsc_sync (
    input  wire logic                  core_clk,
    input  wire logic                  resetn,
    input  irsc_pkg::irsc_lines_t      raw,
    output irsc_pkg::irsc_lines_t      synced
);
    import irsc_pkg::*;

    irsc_lines_t meta_reg;
    irsc_lines_t sync_reg;

    // Two-stage capture of the open-drain lines, idle high
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= '1;
            sync_reg <= '1;
        end else begin
            meta_reg <= raw;
            sync_reg <= meta_reg;
        end
    end

    assign synced = sync_reg;

endmodule : irsc_sync

/* File: irsc_top.sv */
`timescale 1ns/100ps
module irsc_top (
    input  wire logic                        core_clk,
    input  wire logic                        resetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [irsc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [irsc_pkg::DATA_W-1:0] pwdata,
    output logic      [irsc_pkg::DATA_W-1:0] prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  irsc_pkg::irsc_lines_t            line_in,
    output irsc_pkg::irsc_lines_t            line_out,
    output irsc_pkg::irsc_lines_t            line_oe
);
    import irsc_pkg::*;

    irsc_lines_t         ln;
    irsc_lines_t         prev_reg;
    irsc_lines_t         drv_reg;
    irsc_lines_t         drv_next;
    irsc_state_t         st_reg;
    irsc_state_t         st_next;
    logic [REG_W-1:0]    buf_reg;
    logic [REG_W-1:0]    buf_next;
    logic [REG_W-1:0]    reload_reg;
    logic [REG_W-1:0]    reload_next;
    logic [REG_W-1:0]    ctl1_reg;
    logic [REG_W-1:0]    ctl1_next;
    logic [REG_W-1:0]    ctl2_reg;
    logic [REG_W-1:0]    ctl2_next;
    logic [REG_W-1:0]    stat_reg;
    logic [REG_W-1:0]    stat_next;
    logic                coll_reg;
    logic                coll_next;
    logic                pevt_reg;
    logic                pevt_next;
    logic [DATA_W-1:0]   rdata_reg;
    logic [DATA_W-1:0]   rdata_next;
    logic                hit;
    logic                wr_en;
    logic                load;
    logic                expired;
    logic                coll_evt;
    logic                start_seen;
    logic                stop_seen;
    logic                busy;

    irsc_sync u_sync (
        .core_clk (core_clk),
        .resetn   (resetn),
        .raw      (line_in),
        .synced   (ln)
    );

    irsc_baud u_baud (
        .core_clk (core_clk),
        .resetn   (resetn),
        .load     (load),
        .reload   (reload_reg[RELOAD_W-1:0]),
        .cnt      (),
        .expired  (expired)
    );

    // Open drain: only low is ever driven
    assign line_out = '0;
    assign line_oe  = drv_reg;

    // APB slave, zero wait states
    assign pready  = 1'b1;
    assign prdata  = rdata_reg;
    assign hit     = (paddr == OFF_BUF) || (paddr == OFF_RELOAD) || (paddr == OFF_CTL1) ||
                     (paddr == OFF_CTL2) || (paddr == OFF_STAT) || (paddr == OFF_EVT);
    assign pslverr = psel && penable && !hit;
    assign wr_en   = psel && penable && pwrite && hit;
    assign busy    = (st_reg != ST_IDLE);

    // Bus condition monitor on synchronised lines
    assign start_seen = ln.scl && prev_reg.scl && !ln.sda && prev_reg.sda;
    assign stop_seen  = ln.scl && prev_reg.scl && ln.sda && !prev_reg.sda;

    always_comb begin
        rdata_next = rdata_reg;
        if (psel && !penable) begin
            case (paddr)
                OFF_BUF:    rdata_next = {24'h000000, buf_reg};
                OFF_RELOAD: rdata_next = {24'h000000, reload_reg};
                OFF_CTL1:   rdata_next = {24'h000000, ctl1_reg};
                OFF_CTL2:   rdata_next = {24'h000000, ctl2_reg};
                OFF_STAT:   rdata_next = {24'h000000, stat_reg};
                OFF_EVT:    rdata_next = {30'h00000000, pevt_reg, coll_reg};
                default:    rdata_next = 32'h00000000;
            endcase
        end
    end

    always_comb begin
        st_next     = st_reg;
        drv_next    = drv_reg;
        buf_next    = buf_reg;
        reload_next = reload_reg;
        ctl1_next   = ctl1_reg;
        ctl2_next   = ctl2_reg;
        stat_next   = stat_reg;
        coll_next   = coll_reg;
        pevt_next   = pevt_reg;
        load        = 1'b0;
        coll_evt    = 1'b0;
        // Software writes; hardware sets below win
        if (wr_en) begin
            case (paddr)
                OFF_BUF: begin
                    if (busy) begin
                        ctl1_next[CTL1_WCOL] = 1'b1;
                    end else begin
                        buf_next = pwdata[REG_W-1:0];
                    end
                end
                OFF_RELOAD: reload_next = pwdata[REG_W-1:0];
                OFF_CTL1:   ctl1_next   = pwdata[REG_W-1:0];
                OFF_CTL2: begin
                    if (busy) begin
                        ctl2_next = (pwdata[REG_W-1:0] & ~SEQ_MASK) | (ctl2_reg & SEQ_MASK);
                    end else begin
                        ctl2_next = pwdata[REG_W-1:0];
                    end
                end
                OFF_EVT: begin
                    coll_next = coll_reg & ~pwdata[EVT_COLL];
                    pevt_next = pevt_reg & ~pwdata[EVT_PORT];
                end
                default: ;
            endcase
        end
        case (st_reg)
            ST_IDLE: begin
                if (!ctl1_reg[CTL1_EN]) begin
                    ctl2_next = ctl2_next & ~SEQ_MASK;
                end else if (ctl2_reg[CTL2_SEN]) begin
                    if (!ln.sda || !ln.scl) begin
                        coll_evt = 1'b1;
                    end else begin
                        load    = 1'b1;
                        st_next = ST_SEN_CNT1;
                    end
                end else if (ctl2_reg[CTL2_RESTART_SEQ_ENABLE]) begin
                    drv_next = '{scl: 1'b1, sda: 1'b0};
                    st_next  = ST_RS_SDA;
                end else if (ctl2_reg[CTL2_PEN]) begin
                    drv_next = '{scl: 1'b1, sda: 1'b1};
                    st_next  = ST_SP_SDA;
                end else if (ctl2_reg[CTL2_ACK_SEQ_ENABLE]) begin
                    drv_next = '{scl: 1'b1, sda: !ctl2_reg[CTL2_ACKDT]};
                    load     = 1'b1;
                    st_next  = ST_AK_CNT1;
                end
            end
            ST_SEN_CNT1: begin
                if (!ln.scl) begin
                    coll_evt = 1'b1;
                end else if (!ln.sda || expired) begin
                    drv_next.sda = 1'b1;
                    load         = 1'b1;
                    st_next      = ST_SEN_CNT2;
                end
            end
            ST_SEN_CNT2: begin
                if (expired) begin
                    drv_next.scl        = 1'b1;
                    ctl2_next[CTL2_SEN] = 1'b0;
                    st_next             = ST_IDLE;
                end
            end
            ST_RS_SDA: begin
                if (ln.sda) begin
                    load    = 1'b1;
                    st_next = ST_RS_CNT1;
                end
            end
            ST_RS_CNT1: begin
                if (expired) begin
                    drv_next.scl = 1'b0;
                    st_next      = ST_RS_SCL;
                end
            end
            ST_RS_SCL: begin
                if (ln.scl) begin
                    if (!ln.sda) begin
                        coll_evt = 1'b1;
                    end else begin
                        load    = 1'b1;
                        st_next = ST_RS_CNT2;
                    end
                end
            end
            ST_RS_CNT2: begin
                // SDA pulled low here by another master is tolerated
                if (!ln.scl && !drv_reg.sda) begin
                    coll_evt = 1'b1;
                end else if (expired) begin
                    drv_next.sda = 1'b1;
                    load         = 1'b1;
                    st_next      = ST_RS_CNT3;
                end
            end
            ST_RS_CNT3: begin
                if (expired) begin
                    drv_next.scl         = 1'b1;
                    ctl2_next[CTL2_RESTART_SEQ_ENABLE] = 1'b0;
                    st_next              = ST_IDLE;
                end
            end
            ST_SP_SDA: begin
                if (!ln.sda) begin
                    drv_next.scl = 1'b0;
                    st_next      = ST_SP_SCL;
                end
            end
            ST_SP_SCL: begin
                if (ln.scl) begin
                    load    = 1'b1;
                    st_next = ST_SP_CNT1;
                end
            end
            ST_SP_CNT1: begin
                if (!ln.scl) begin
                    coll_evt = 1'b1;
                end else if (expired) begin
                    drv_next.sda = 1'b0;
                    load         = 1'b1;
                    st_next      = ST_SP_CNT2;
                end
            end
            ST_SP_CNT2: begin
                // Reload below two expires before released SDA returns through the synchroniser
                if (!ln.scl && !ln.sda) begin
                    coll_evt = 1'b1;
                end else if (expired) begin
                    if (!ln.sda) begin
                        coll_evt = 1'b1;
                    end else begin
                        ctl2_next[CTL2_PEN] = 1'b0;
                        pevt_next           = 1'b1;
                        st_next             = ST_IDLE;
                    end
                end
            end
            ST_AK_CNT1: begin
                if (expired) begin
                    drv_next.scl = 1'b0;
                    st_next      = ST_AK_SCL;
                end
            end
            ST_AK_SCL: begin
                if (ln.scl) begin
                    load    = 1'b1;
                    st_next = ST_AK_CNT2;
                end
            end
            ST_AK_CNT2: begin
                if (!drv_reg.sda && !ln.sda) begin
                    coll_evt = 1'b1;
                end else if (expired) begin
                    drv_next              = '{scl: 1'b1, sda: 1'b0};
                    ctl2_next[CTL2_ACK_SEQ_ENABLE] = 1'b0;
                    pevt_next             = 1'b1;
                    st_next               = ST_IDLE;
                end
            end
            default: st_next = ST_IDLE;
        endcase
        if (coll_evt) begin
            drv_next  = '0;
            ctl2_next = ctl2_next & ~SEQ_MASK;
            coll_next = 1'b1;
            load      = 1'b0;
            st_next   = ST_IDLE;
        end
        if (!ctl1_reg[CTL1_EN]) begin
            stat_next = REG_W'(0);
        end else if (stop_seen) begin
            stat_next[STAT_P] = 1'b1;
            stat_next[STAT_S] = 1'b0;
            pevt_next         = 1'b1;
        end else if (start_seen) begin
            stat_next[STAT_S] = 1'b1;
            stat_next[STAT_P] = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg     <= ST_IDLE;
            drv_reg    <= '0;
            prev_reg   <= '1;
            buf_reg    <= REG_RST;
            reload_reg <= REG_RST;
            ctl1_reg   <= REG_RST;
            ctl2_reg   <= REG_RST;
            stat_reg   <= REG_RST;
            coll_reg   <= 1'b0;
            pevt_reg   <= 1'b0;
            rdata_reg  <= 32'h00000000;
        end else begin
            st_reg     <= st_next;
            drv_reg    <= drv_next;
            prev_reg   <= ln;
            buf_reg    <= buf_next;
            reload_reg <= reload_next;
            ctl1_reg   <= ctl1_next;
            ctl2_reg   <= ctl2_next;
            stat_reg   <= stat_next;
            coll_reg   <= coll_next;
            pevt_reg   <= pevt_next;
            rdata_reg  <= rdata_next;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    chk_rs_sda_low : assert property (
        (st_reg == ST_RS_SCL && ln.scl && !ln.sda) |=> (st_reg == ST_IDLE && coll_reg))
        else $error("no collision on low SDA at SCL rise");
    chk_rs_scl_fall : assert property (
        (st_reg == ST_RS_CNT2 && !ln.scl && !drv_reg.sda) |=> (coll_reg && drv_reg == '0))
        else $error("early SCL fall not flagged");
    chk_rs_load : assert property (
        (st_reg == ST_RS_SDA && ln.sda) |=> (st_reg == ST_RS_CNT1 && drv_reg.scl))
        else $error("countdown not started on released SDA");
    chk_rs_reload : assert property (
        (st_reg == ST_RS_SCL && ln.scl && ln.sda) |=> (st_reg == ST_RS_CNT2 && !drv_reg.scl))
        else $error("no reload after high SDA");
    chk_rs_sda_early : assert property (
        (st_reg == ST_RS_CNT2 && ln.scl && !ln.sda && !coll_reg) |=> !coll_reg)
        else $error("early SDA fall wrongly flagged");
    chk_rs_drive : assert property (
        (st_reg == ST_RS_CNT2 && expired && ln.scl && ln.sda) |=> (drv_reg.sda && st_reg == ST_RS_CNT3))
        else $error("SDA not driven at expiry");
    chk_rs_done : assert property (
        (st_reg == ST_RS_CNT3 && expired) |=> (drv_reg.scl && !ctl2_reg[CTL2_RESTART_SEQ_ENABLE] && st_reg == ST_IDLE))
        else $error("repeated start not closed");
    chk_sp_release : assert property (
        (st_reg == ST_SP_SDA && !ln.sda) |=> (!drv_reg.scl && drv_reg.sda))
        else $error("SCL not released in stop");
    chk_sp_sda_late : assert property (
        (st_reg == ST_SP_CNT2 && expired && ln.scl && !ln.sda) |=> coll_reg)
        else $error("low SDA after stop count missed");
    chk_sp_scl_low : assert property (
        (st_reg == ST_SP_CNT1 && !ln.scl) |=> (coll_reg && st_reg == ST_IDLE))
        else $error("SCL low during stop missed");
    chk_coll_abort : assert property (
        coll_evt |=> (drv_reg == '0 && (ctl2_reg & SEQ_MASK) == '0 && st_reg == ST_IDLE && coll_reg))
        else $error("collision did not abort");
    chk_stop_event : assert property (
        (stop_seen && ctl1_reg[CTL1_EN]) |=> (pevt_reg && stat_reg[STAT_P]))
        else $error("bus stop not reported");

    cov_rs_done : cover property (st_reg == ST_RS_CNT3 && expired);
    cov_sp_done : cover property (st_reg == ST_SP_CNT2 && expired && ln.sda);
    cov_rs_coll : cover property (coll_evt && st_reg == ST_RS_SCL);
    cov_sp_coll : cover property (coll_evt && st_reg == ST_SP_CNT1);

endmodule : irsc_top

/* File: test_i2c_master_rstart_stop_collision.sv */
`timescale 1ns/100ps
module test_i2c_master_rstart_stop_collision;
    import irsc_pkg::*;
    localparam logic [7:0] OFF_NONE = 8'h18;
    logic              core_clk   = 1'b0;
    logic              resetn     = 1'b0;
    logic              psel       = 1'b0;
    logic              penable    = 1'b0;
    logic              pwrite     = 1'b0;
    logic [ADDR_W-1:0] paddr      = '0;
    logic [DATA_W-1:0] pwdata     = '0;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              pull_scl   = 1'b0;
    logic              pull_sda   = 1'b0;
    irsc_lines_t       line_in;
    irsc_lines_t       line_oe;
    irsc_lines_t       peer_oe;
    logic [DATA_W-1:0] rd;
    logic              err;
    int                num_errors = 0;
    int                n_compared = 0;
    int                cyc        = 0;
    int                n;
    int                gap;
    int                mdl [6]    = '{0, 0, 0, 0, 0, 0};
    // Collision cases: sequence bit, reload, wait on scl release, delay, which line the peer pulls, collision
    int                c_bit [5]  = '{2, 2, 2, 4, 4};
    int                c_n [5]    = '{20, 60, 60, 20, 60};
    int                c_dly [5]  = '{0, 12, 12, 0, 12};
    logic              c_sda [5]  = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    logic              c_col [5]  = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};

    always #4 core_clk = ~core_clk;
    assign line_in.scl = ~(line_oe.scl | peer_oe.scl);
    assign line_in.sda = ~(line_oe.sda | peer_oe.sda);

    irsc_top dut (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
                  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
                  .line_in(line_in), .line_out(), .line_oe(line_oe));
    irsc_peer peer (.core_clk(core_clk), .pull_scl(pull_scl), .pull_sda(pull_sda), .peer_oe(peer_oe));

    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input int d);
        apb(1'b1, a, 32'(d));
    endtask : wr

    task automatic rd_chk(input logic [7:0] a);
        apb(1'b0, a, '0);
        check(rd, mdl[a[4:2]]);
    endtask : rd_chk

    task automatic wait_idle();
        do apb(1'b0, OFF_CTL2, '0); while ((rd[7:0] & SEQ_MASK) != 8'h00);
    endtask : wait_idle

    task automatic wait_scl_oe(input logic v);
        while (line_oe.scl !== v) @(posedge core_clk);
    endtask : wait_scl_oe

    initial begin
        void'($urandom(99215));
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        for (int a = 0; a < 6; a++) begin
            rd_chk(8'(a * 4));
        end
        apb(1'b0, OFF_NONE, '0);
        check(err, 1'b1);
        check(rd, '0);
        wr(OFF_CTL1, 32'h20);
        mdl[2] = 32'h20;
        // Clean repeated start: third count spans reload plus one cycles
        // Reloads below two expire before a released SDA is seen back through the synchroniser
        n = 2 + $urandom % 19;
        wr(OFF_RELOAD, n);
        mdl[1] = n;
        wr(OFF_CTL2, 2);
        while (line_oe.sda !== 1'b1) @(posedge core_clk);
        gap = 0;
        while (line_oe.scl !== 1'b1) begin
            @(posedge core_clk);
            gap++;
        end
        check(gap, n + 1);
        wait_idle();
        rd_chk(OFF_EVT);
        check(line_oe, 2'b11);
        // Clean stop
        wr(OFF_CTL2, 4);
        wait_idle();
        mdl[5] = 2;
        rd_chk(OFF_EVT);
        apb(1'b0, OFF_STAT, '0);
        check(rd[STAT_P], 1'b1);
        check(line_oe, 2'b00);
        wr(OFF_EVT, 3);
        for (int i = 0; i < 5; i++) begin
            wr(OFF_RELOAD, c_n[i]);
            wr(OFF_CTL2, c_bit[i]);
            // Repeated start low-SDA case: the peer pulls SDA while SCL is still held low
            if (c_dly[i] != 0 || c_bit[i] == 2) begin
                wait_scl_oe(1'b1);
            end
            if (c_dly[i] != 0) begin
                wait_scl_oe(1'b0);
                repeat (c_dly[i]) @(posedge core_clk);
            end
            pull_sda <= c_sda[i];
            pull_scl <= ~c_sda[i];
            wait_idle();
            mdl[5] = c_col[i] ? 1 : 0;
            rd_chk(OFF_EVT);
            check(line_oe, c_col[i] ? 2'b00 : 2'b11);
            pull_sda <= 1'b0;
            pull_scl <= 1'b0;
            repeat (10) @(posedge core_clk);
            wr(OFF_EVT, 3);
        end
        mdl[5] = 0;
        rd_chk(OFF_CTL2);
        // Clean start, acknowledge and closing stop: acknowledge and stop raise the port flag
        for (int s = 0; s < 3; s++) begin
            wr(OFF_CTL2, (s == 0) ? 1 : ((s == 1) ? 16 : 4));
            wait_idle();
        end
        mdl[5] = 2;
        rd_chk(OFF_EVT);
        check(line_oe, 2'b00);
        wr(OFF_EVT, 3);
        mdl[5] = 0;
        // Another master closes the bus with a stop, edges 80 ns apart
        for (int k = 0; k < 4; k++) begin
            pull_sda <= (k < 3);
            pull_scl <= (k == 1);
            repeat (10) @(posedge core_clk);
        end
        apb(1'b0, OFF_EVT, '0);
        check(rd[EVT_PORT], 1'b1);
        tally_and_finish();
    end
endmodule : test_i2c_master_rstart_stop_collision
